/* src/rsq_pkg.sv */
// Constants and types of the reset and start-up sequencer
// Notes on behaviour
// - Separate causes: power-on, pin, sleep-pin, watchdog, brown-out, parity
// - Reset-state load except on watchdog or interrupt wake-up
// - Unreset registers keep contents; undefined after power-on
// - Reset pin filtered against short pulses
// - Watchdog reset never drives the reset pin
// - Supply rising through window makes power-on pulse
// - Power-up timer holds reset 72 ms
// - Config bit enables or skips power-up timer
// - Oscillator start-up timer adds 1024 input cycles
// - Start-up timer only crystal modes, power-on, brown-out, wake
// - Brown-out enable bit gates brown-out reset
// - Only sustained low supply causes brown-out reset
// - Hold until recovery, then 72 ms power-up timer when its config bit enables it
// - Dip during power-up timer restarts it
// - Power-up timer then start-up timer; RC none
// - Time-outs ignore pin; release starts immediately
// - RC mode drives oscillator divided by four
// - Status flags pattern identifies reset cause
// - Power-on flag cleared only by power-on
// - Brown-out flag cleared by brown-out reset
package rsq_pkg;

  localparam int CLK_PERIOD_NS = 10;

  localparam int POWERUP_TIMER_TIME_MS = 72;
  localparam int RC_TICK_NS   = 1000000;
  localparam int RC_TICK_CYC  = RC_TICK_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] POWERUP_TIMER_TICKS = 11'h048;
  localparam logic [CNT_W-1:0] OST_EDGES  = 11'h400;

  localparam int PIN_FILT_NS  = 100;
  localparam int PIN_FILT_CYC =
    (PIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_MIN_NS   = 2000;
  localparam int BOD_MIN_CYC  =
    (BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] OSC_LP = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_HS = 2'h2;
  localparam logic [1:0] OSC_RC = 2'h3;

  localparam logic RST_TO      = 1'h1;
  localparam logic RST_PD      = 1'h1;
  localparam logic RST_POR_B   = 1'h0;
  localparam logic RST_BOR_B   = 1'h1;
  localparam logic RST_PER_B   = 1'h1;

  typedef enum logic [2:0] {
    ST_POR, ST_BOR, ST_POWERUP_TIMER, ST_OST, ST_RUN, ST_SLEEP
  } rsq_state_t;

  typedef enum logic [2:0] {
    CAUSE_POR, CAUSE_PIN_RUN, CAUSE_PIN_SLEEP, CAUSE_WDT,
    CAUSE_WDT_WAKE, CAUSE_BOR, CAUSE_PARITY, CAUSE_IRQ_WAKE
  } rsq_cause_t;

endpackage

/* src/rsq_tick_div.sv */
// Clock divider giving a one-cycle enable pulse
`timescale 1ns/100ps
module rsq_tick_div #(
  parameter int DIV = 100000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic clear,
  // Enable out
  output logic      tick
);

  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    if (clear || cnt_ff == LAST) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = !clear && cnt_ff == LAST;

endmodule

/* src/rsq_deglitch.sv */
// Two-flop synchroniser with a stable-level filter
`timescale 1ns/100ps
module rsq_deglitch #(
  parameter int   FILT_CYC = 10,
  parameter logic RST_VAL  = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Raw asynchronous level
  input  wire logic rawIn,
  // Filtered level
  output logic      level
);

  localparam int W = $clog2(FILT_CYC + 1);
  localparam logic [W-1:0] LAST = W'(FILT_CYC - 1);

  logic         sync1_ff;
  logic         sync2_ff;
  logic         level_ff;
  logic         nxt_level;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Level only flips after FILT_CYC equal samples
  always_comb begin
    nxt_level = level_ff;
    nxt_cnt   = '0;
    if (sync2_ff != level_ff) begin
      if (cnt_ff == LAST) begin
        nxt_level = sync2_ff;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_ff <= RST_VAL;
      sync2_ff <= RST_VAL;
      level_ff <= RST_VAL;
      cnt_ff   <= '0;
    end else begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
      level_ff <= nxt_level;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign level = level_ff;

endmodule

/* src/rsq_sequencer.sv */
// Reset source merge, start-up timers and reset-cause flags
`timescale 1ns/100ps
module rsq_sequencer
  import rsq_pkg::*;
#(
  parameter int TICK_CYC = RC_TICK_CYC,
  parameter int BOD_CYC  = BOD_MIN_CYC,
  parameter int PIN_CYC  = PIN_FILT_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Supply detector and pins
  input  wire logic       vddAbovePorLevel,
  input  wire logic       vddBelowBrownout,
  input  wire logic       extResetPin_b,
  input  wire logic       oscInputPin,
  // Configuration
  input  wire logic       brownoutEnableCfg,
  input  wire logic       powerupTimerEnCfg,
  input  wire logic       parityEnableCfg,
  input  wire logic [1:0] oscModeCfg,
  // Core events
  input  wire logic       watchdogTimeout,
  input  wire logic       parityError,
  input  wire logic       sleepEnter,
  input  wire logic       wdtClear,
  input  wire logic       irqWake,
  input  wire logic       swSetPorFlag,
  input  wire logic       swSetBorFlag,
  input  wire logic       swSetPerFlag,
  // Core reset and status
  output logic            chipReset,
  output logic            regLoadReset,
  output logic            coldStart,
  output rsq_cause_t      resetCause,
  output logic            timeoutFlag,
  output logic            powerdownFlag,
  output logic            porFlag_b,
  output logic            borFlag_b,
  output logic            perFlag_b,
  // Pin drivers
  output logic            instrClockOut,
  output logic            instrClockOutOe,
  output logic            extResetPinOe
);

  rsq_state_t       state_ff;
  rsq_state_t       nxt_state;
  rsq_cause_t       cause_ff;
  rsq_cause_t       nxt_cause;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             chipReset_ff;
  logic             nxt_chipReset;
  logic             regLoad_ff;
  logic             nxt_regLoad;
  logic             cold_ff;
  logic             nxt_cold;
  logic             pinLowD_ff;
  logic             porS1_ff;
  logic             porS2_ff;
  logic             porD_ff;
  logic             oscS1_ff;
  logic             oscS2_ff;
  logic             oscD_ff;
  logic [1:0]       div_ff;
  logic [1:0]       nxt_div;
  logic             clkOut_ff;
  logic             clkOe_ff;
  logic             to_ff;
  logic             pd_ff;
  logic             por_b_ff;
  logic             bor_b_ff;
  logic             per_b_ff;
  logic             nxt_to;
  logic             nxt_pd;
  logic             nxt_por_b;
  logic             nxt_bor_b;
  logic             nxt_per_b;

  logic pinLowF;
  logic pinHighF;
  logic bodLowF;
  logic borActive;
  logic crystal;
  logic porEvt;
  logic oscEdge;
  logic rcTick;
  logic tickClear;
  logic evPor;
  logic evBor;
  logic evWdtRst;
  logic evWdtWake;
  logic evPinSleep;
  logic evIrqWake;
  logic evPer;

  // Filter instances carry their own two-flop synchronisers
  rsq_deglitch #(
    .FILT_CYC (PIN_CYC),
    .RST_VAL  (1'b1)
  ) u_pin_filt (
    .clk   (clk),
    .rst_b (rst_b),
    .rawIn (extResetPin_b),
    .level (pinHighF)
  );
  assign pinLowF = !pinHighF;

  rsq_deglitch #(
    .FILT_CYC (BOD_CYC),
    .RST_VAL  (1'b0)
  ) u_bod_filt (
    .clk   (clk),
    .rst_b (rst_b),
    .rawIn (vddBelowBrownout),
    .level (bodLowF)
  );
  assign borActive = brownoutEnableCfg && bodLowF;

  rsq_tick_div #(
    .DIV (TICK_CYC)
  ) u_rc_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (tickClear),
    .tick  (rcTick)
  );

  assign crystal = oscModeCfg != OSC_RC;
  assign porEvt  = porS2_ff && !porD_ff;
  assign oscEdge = oscS2_ff && !oscD_ff;

  // Watchdog stays internal; the pin is never driven
  assign extResetPinOe = 1'b0;

  function automatic rsq_state_t afterPwrt(input logic xtal);
    afterPwrt = xtal ? ST_OST : ST_RUN;
  endfunction

  function automatic rsq_state_t startSeq(input logic pwrtEn,
                                          input logic xtal);
    if (pwrtEn) begin
      startSeq = ST_POWERUP_TIMER;
    end else begin
      startSeq = afterPwrt(xtal);
    end
  endfunction

  // Sequencer state, cause and reset strobes
  always_comb begin
    nxt_state  = state_ff;
    nxt_cause  = cause_ff;
    nxt_cnt    = cnt_ff;
    nxt_regLoad = 1'b0;
    nxt_cold   = 1'b0;
    tickClear  = 1'b0;
    evPor      = 1'b0;
    evBor      = 1'b0;
    evWdtRst   = 1'b0;
    evWdtWake  = 1'b0;
    evPinSleep = 1'b0;
    evIrqWake  = 1'b0;
    evPer      = 1'b0;
    if (porEvt) begin
      nxt_state = ST_POR;
    end else if (borActive && state_ff != ST_POR
                 && state_ff != ST_BOR) begin
      // Also restarts a running power-up timer
      nxt_state   = ST_BOR;
      nxt_cause   = CAUSE_BOR;
      nxt_cnt     = '0;
      tickClear   = 1'b1;
      evBor       = 1'b1;
      nxt_regLoad = 1'b1;
    end else begin
      case (state_ff)
        ST_POR: begin
          nxt_cause   = CAUSE_POR;
          evPor       = 1'b1;
          nxt_regLoad = 1'b1;
          nxt_cold    = 1'b1;
          nxt_cnt     = '0;
          tickClear   = 1'b1;
          nxt_state   = startSeq(powerupTimerEnCfg, crystal);
        end
        ST_BOR: begin
          if (!borActive) begin
            nxt_cnt   = '0;
            tickClear = 1'b1;
            nxt_state = startSeq(powerupTimerEnCfg, crystal);
          end
        end
        ST_POWERUP_TIMER: begin
          if (rcTick) begin
            if (cnt_ff == POWERUP_TIMER_TICKS - 11'h001) begin
              nxt_cnt   = '0;
              nxt_state = afterPwrt(crystal);
            end else begin
              nxt_cnt = cnt_ff + 11'h001;
            end
          end
        end
        ST_OST: begin
          if (oscEdge) begin
            if (cnt_ff == OST_EDGES - 11'h001) begin
              nxt_cnt   = '0;
              nxt_state = ST_RUN;
            end else begin
              nxt_cnt = cnt_ff + 11'h001;
            end
          end
        end
        ST_RUN: begin
          if (pinLowF) begin
            if (!pinLowD_ff) begin
              nxt_cause   = CAUSE_PIN_RUN;
              nxt_regLoad = 1'b1;
            end
          end else if (watchdogTimeout) begin
            nxt_cause   = CAUSE_WDT;
            evWdtRst    = 1'b1;
            nxt_regLoad = 1'b1;
          end else if (parityError && parityEnableCfg) begin
            nxt_cause   = CAUSE_PARITY;
            evPer       = 1'b1;
            nxt_regLoad = 1'b1;
          end else if (sleepEnter) begin
            nxt_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          nxt_cnt = '0;
          if (pinLowF) begin
            // No start-up timer on a pin reset from sleep
            nxt_cause   = CAUSE_PIN_SLEEP;
            evPinSleep  = 1'b1;
            nxt_regLoad = 1'b1;
            nxt_state   = ST_RUN;
          end else if (watchdogTimeout) begin
            // Wake-up resumes; registers are left alone
            nxt_cause = CAUSE_WDT_WAKE;
            evWdtWake = 1'b1;
            nxt_state = afterPwrt(crystal);
          end else if (irqWake) begin
            nxt_cause = CAUSE_IRQ_WAKE;
            evIrqWake = 1'b1;
            nxt_state = afterPwrt(crystal);
          end
        end
        default: begin
          nxt_state = ST_POR;
        end
      endcase
    end
    // Timers run whatever the pin does
    nxt_chipReset = (nxt_state != ST_RUN && nxt_state != ST_SLEEP)
                    || pinLowF || evWdtRst || evPer;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff     <= ST_POR;
      cause_ff     <= CAUSE_POR;
      cnt_ff       <= '0;
      chipReset_ff <= 1'b1;
      regLoad_ff   <= 1'b0;
      cold_ff      <= 1'b0;
      pinLowD_ff   <= 1'b0;
      porS1_ff     <= 1'b1;
      porS2_ff     <= 1'b1;
      porD_ff      <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      cause_ff     <= nxt_cause;
      cnt_ff       <= nxt_cnt;
      chipReset_ff <= nxt_chipReset;
      regLoad_ff   <= nxt_regLoad;
      cold_ff      <= nxt_cold;
      pinLowD_ff   <= pinLowF;
      porS1_ff     <= vddAbovePorLevel;
      porS2_ff     <= porS1_ff;
      porD_ff      <= porS2_ff;
    end
  end

  // Status flags; a hardware clear beats a software set
  always_comb begin
    nxt_to    = to_ff;
    nxt_pd    = pd_ff;
    nxt_por_b = por_b_ff | swSetPorFlag;
    nxt_bor_b = bor_b_ff | swSetBorFlag;
    nxt_per_b = per_b_ff | swSetPerFlag;
    if (wdtClear) begin
      nxt_to = 1'b1;
      nxt_pd = 1'b1;
    end
    if (sleepEnter && state_ff == ST_RUN) begin
      nxt_to = 1'b1;
      nxt_pd = 1'b0;
    end
    if (evPor) begin
      nxt_to    = 1'b1;
      nxt_pd    = 1'b1;
      nxt_por_b = 1'b0;
      nxt_per_b = 1'b1;
    end else if (evBor) begin
      nxt_to    = 1'b1;
      nxt_pd    = 1'b1;
      nxt_bor_b = 1'b0;
    end else if (evWdtRst) begin
      nxt_to = 1'b0;
      nxt_pd = 1'b1;
    end else if (evWdtWake) begin
      nxt_to = 1'b0;
      nxt_pd = 1'b0;
    end else if (evPinSleep || evIrqWake) begin
      nxt_to = 1'b1;
      nxt_pd = 1'b0;
    end else if (evPer) begin
      nxt_to    = 1'b1;
      nxt_pd    = 1'b1;
      nxt_per_b = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      to_ff    <= RST_TO;
      pd_ff    <= RST_PD;
      por_b_ff <= RST_POR_B;
      bor_b_ff <= RST_BOR_B;
      per_b_ff <= RST_PER_B;
    end else begin
      to_ff    <= nxt_to;
      pd_ff    <= nxt_pd;
      por_b_ff <= nxt_por_b;
      bor_b_ff <= nxt_bor_b;
      per_b_ff <= nxt_per_b;
    end
  end

  // Oscillator input edges and the divide-by-four clock out
  always_comb begin
    nxt_div = div_ff;
    if (oscEdge) begin
      nxt_div = div_ff + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      oscS1_ff  <= 1'b0;
      oscS2_ff  <= 1'b0;
      oscD_ff   <= 1'b0;
      div_ff    <= 2'h0;
      clkOut_ff <= 1'b0;
      clkOe_ff  <= 1'b0;
    end else begin
      oscS1_ff  <= oscInputPin;
      oscS2_ff  <= oscS1_ff;
      oscD_ff   <= oscS2_ff;
      div_ff    <= nxt_div;
      clkOut_ff <= div_ff[1];
      clkOe_ff  <= !crystal;
    end
  end

  assign chipReset       = chipReset_ff;
  assign regLoadReset    = regLoad_ff;
  assign coldStart       = cold_ff;
  assign resetCause      = cause_ff;
  assign timeoutFlag     = to_ff;
  assign powerdownFlag   = pd_ff;
  assign porFlag_b       = por_b_ff;
  assign borFlag_b       = bor_b_ff;
  assign perFlag_b       = per_b_ff;
  assign instrClockOut   = clkOut_ff;
  assign instrClockOutOe = clkOe_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_timer_holds: assert property (
    (state_ff == ST_POWERUP_TIMER || state_ff == ST_OST) |-> chipReset)
    else $error("reset dropped while a timer runs");

  a_powerup_timer_restart: assert property (
    (state_ff == ST_POWERUP_TIMER && borActive && !porEvt)
    |=> (state_ff == ST_BOR && cnt_ff == 11'h000))
    else $error("brown-out did not restart power-up timer");

  a_bor_disabled: assert property (
    (!brownoutEnableCfg && state_ff != ST_BOR)
    |=> state_ff != ST_BOR)
    else $error("brown-out entered while disabled");

  a_por_flags: assert property (
    evPor |=> (!porFlag_b && timeoutFlag && powerdownFlag))
    else $error("power-on flag pattern wrong");

  a_bor_flag: assert property (
    evBor |=> (!borFlag_b && resetCause == CAUSE_BOR))
    else $error("brown-out flag not cleared");

  a_wdt_wake_keep: assert property (
    evWdtWake |=> (!regLoadReset && !timeoutFlag && !powerdownFlag))
    else $error("watchdog wake-up reloaded registers");

  a_ost_end: assert property (
    (state_ff == ST_OST && oscEdge && cnt_ff == 11'h3FF && !porEvt
     && !borActive) |=> state_ff == ST_RUN ##1 !chipReset || pinLowF)
    else $error("start-up timer end wrong");

  a_rc_no_ost: assert property (
    (!crystal && state_ff != ST_OST) |=> state_ff != ST_OST)
    else $error("start-up timer used in RC mode");

  a_pin_release: assert property (
    (state_ff == ST_RUN && !pinLowF && !watchdogTimeout
     && !(parityError && parityEnableCfg) && !porEvt && !borActive)
    |=> !chipReset)
    else $error("execution not started on pin release");

  a_wdt_pin_free: assert property (
    watchdogTimeout |-> ##[0:2] !extResetPinOe)
    else $error("reset pin driven on watchdog");

  a_clkout_oe: assert property (
    crystal |=> !instrClockOutOe)
    else $error("clock out driven in crystal mode");

  c_por_run: cover property (state_ff == ST_OST ##1 state_ff == ST_RUN);
  c_bor_seq: cover property (evBor ##[1:50] state_ff == ST_POWERUP_TIMER);
  c_wdt_wake: cover property (evWdtWake);
  c_pin_sleep: cover property (evPinSleep);

endmodule

/* tb/rsq_partner.sv */
// Supply detector, reset pin driver and crystal model
`timescale 1ns/100ps
module rsq_partner (
  // Clock
  input  wire logic clk,
  // Detector, pin and oscillator outputs
  output logic      vddAbovePorLevel,
  output logic      vddBelowBrownout,
  output logic      extResetPin_b,
  output logic      oscInputPin
);
  logic [1:0] oscDiv;

  initial begin
    vddAbovePorLevel = 1'b1;
    vddBelowBrownout = 1'b0;
    extResetPin_b    = 1'b1;
    oscInputPin      = 1'b0;
    oscDiv           = 2'h0;
  end

  // Crystal runs free at a quarter of clk, whatever the chip does
  always @(posedge clk) begin
    oscDiv      <= oscDiv + 2'h1;
    oscInputPin <= oscDiv[1];
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Supply falls to zero and ramps back through the detection window
  task automatic power_cycle();
    @(posedge clk) vddAbovePorLevel <= 1'b0;
    hold(6);
    vddAbovePorLevel <= 1'b1;
  endtask

  task automatic dip(input int n);
    @(posedge clk) vddBelowBrownout <= 1'b1;
    hold(n);
    vddBelowBrownout <= 1'b0;
  endtask

  // Pin has a pull-up, so release returns it high
  task automatic pin_low(input int n);
    @(posedge clk) extResetPin_b <= 1'b0;
    hold(n);
    extResetPin_b <= 1'b1;
  endtask
endmodule

/* tb/rsq_sequencer_bench.sv */
// Self-checking bench of the reset and start-up sequencer
`timescale 1ns/100ps
module rsq_sequencer_bench;
  import rsq_pkg::*;
  localparam int TICK = 5;
  localparam int PW   = 72 * TICK;
  localparam int OS   = 1024 * 4;

  logic       clk, rst_b, vddAbove, vddBelow, pinB, oscIn;
  logic       brownoutEnableCfg, powerupTimerEnCfg, parityEnableCfg;
  logic [1:0] oscModeCfg;
  logic [7:0] evt;
  logic       wdtTo, parErr, sleepGo, irqGo;
  logic       wdtClr, setPor, setBor, setPer;
  logic       chipReset, regLoadReset, coldStart, timeoutFlag;
  logic       powerdownFlag, porFlag_b, borFlag_b, perFlag_b;
  logic       instrClockOut, instrClockOutOe, extResetPinOe;
  rsq_cause_t resetCause;
  logic [4:0] flagVec;
  int         error_cnt, checks_done;

  assign flagVec = {timeoutFlag, powerdownFlag, porFlag_b, borFlag_b,
                    perFlag_b};
  assign {setPer, setBor, setPor, wdtClr, irqGo, sleepGo, parErr,
          wdtTo} = evt;

  rsq_partner rsq_partner_i (.clk(clk), .vddAbovePorLevel(vddAbove),
    .vddBelowBrownout(vddBelow), .extResetPin_b(pinB),
    .oscInputPin(oscIn));

  rsq_sequencer #(.TICK_CYC(TICK), .BOD_CYC(4), .PIN_CYC(3))
  rsq_sequencer_i (.clk(clk), .rst_b(rst_b), .vddAbovePorLevel(vddAbove),
    .vddBelowBrownout(vddBelow), .extResetPin_b(pinB),
    .oscInputPin(oscIn), .brownoutEnableCfg(brownoutEnableCfg),
    .powerupTimerEnCfg(powerupTimerEnCfg),
    .parityEnableCfg(parityEnableCfg), .oscModeCfg(oscModeCfg),
    .watchdogTimeout(wdtTo), .parityError(parErr), .sleepEnter(sleepGo),
    .irqWake(irqGo), .wdtClear(wdtClr), .swSetPorFlag(setPor),
    .swSetBorFlag(setBor), .swSetPerFlag(setPer), .chipReset(chipReset),
    .regLoadReset(regLoadReset), .coldStart(coldStart),
    .resetCause(resetCause), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag), .porFlag_b(porFlag_b),
    .borFlag_b(borFlag_b), .perFlag_b(perFlag_b),
    .instrClockOut(instrClockOut), .instrClockOutOe(instrClockOutOe),
    .extResetPinOe(extResetPinOe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string w, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", w, exp, seen);
    end
  endtask

  task automatic range_chk(input string w, input int n, lo, hi);
    check(w, 16'(n >= lo && n <= hi), 16'h1);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle core event; bit k of evt
  task automatic pulse(input int k);
    @(posedge clk) evt <= 8'h01 << k;
    @(posedge clk) evt <= 8'h00;
    #1;
  endtask

  task automatic wait_run(input int lim, output int n);
    n = 0;
    while (chipReset !== 1'b0 && n < lim) begin
      step(1);
      n++;
    end
  endtask

  task automatic wait_cold();
    int n;
    n = 0;
    while (coldStart !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    check("coldStart", 16'(coldStart), 16'h1);
  endtask

  task automatic wait_clk_out(input logic v, inout int n);
    while (instrClockOut !== v && n < 100) begin
      step(1);
      n++;
    end
  endtask

  task automatic t_power_xt();
    int n;
    wait_cold();
    check("regLoad", 16'(regLoadReset), 16'h1);
    check("cause", 16'(resetCause), 16'(CAUSE_POR));
    check("flags", 16'(flagVec), 16'h1B);
    check("clkOutOe", 16'(instrClockOutOe), 16'h0);
    wait_run(6000, n);
    range_chk("xtStart", n, PW + OS - 8, PW + OS + 24);
  endtask

  task automatic t_wdt();
    pulse(5);
    pulse(6);
    pulse(7);
    step(1);
    check("swSet", 16'(flagVec), 16'h1F);
    pulse(0);
    check("wdtRst", 16'(chipReset), 16'h1);
    check("regLoad", 16'(regLoadReset), 16'h1);
    check("cause", 16'(resetCause), 16'(CAUSE_WDT));
    check("flags", 16'(flagVec), 16'h0F);
    check("pinOe", 16'(extResetPinOe), 16'h0);
    step(1);
    check("noOst", 16'(chipReset), 16'h0);
  endtask

  task automatic t_pin();
    int n;
    rsq_partner_i.pin_low(2);
    step(6);
    check("glitch", 16'(chipReset), 16'h0);
    fork
      rsq_partner_i.pin_low(20);
      begin
        step(12);
        check("pinRst", 16'(chipReset), 16'h1);
        check("cause", 16'(resetCause), 16'(CAUSE_PIN_RUN));
        check("flags", 16'(flagVec), 16'h0F);
      end
    join
    wait_run(12, n);
    check("pinRel", 16'(chipReset), 16'h0);
    pulse(4);
    check("wdtClr", 16'(flagVec), 16'h1F);
  endtask

  task automatic t_sleep();
    int n;
    pulse(2);
    step(1);
    check("sleep", 16'(flagVec), 16'h17);
    pulse(0);
    step(1);
    check("cause", 16'(resetCause), 16'(CAUSE_WDT_WAKE));
    check("noLoad", 16'(regLoadReset), 16'h0);
    check("flags", 16'(flagVec), 16'h07);
    wait_run(4300, n);
    range_chk("wakeOst", n, OS - 8, OS + 16);
    pulse(2);
    pulse(3);
    step(1);
    check("cause", 16'(resetCause), 16'(CAUSE_IRQ_WAKE));
    wait_run(4300, n);
    range_chk("irqOst", n, OS - 8, OS + 16);
    pulse(2);
    fork
      rsq_partner_i.pin_low(20);
      begin
        step(12);
        check("cause", 16'(resetCause), 16'(CAUSE_PIN_SLEEP));
        check("flags", 16'(flagVec), 16'h17);
      end
    join
    wait_run(12, n);
    check("pinWake", 16'(chipReset), 16'h0);
    @(posedge clk) parityEnableCfg <= 1'b0;
    pulse(1);
    check("parOff", 16'(chipReset), 16'h0);
    @(posedge clk) parityEnableCfg <= 1'b1;
    pulse(1);
    step(1);
    check("cause", 16'(resetCause), 16'(CAUSE_PARITY));
    check("flags", 16'(flagVec), 16'h1E);
    wait_run(12, n);
    check("perEnd", 16'(chipReset), 16'h0);
  endtask

  task automatic t_brownout();
    int n;
    @(posedge clk) oscModeCfg <= OSC_RC;
    step(8);
    check("clkOutOe", 16'(instrClockOutOe), 16'h1);
    n = 0;
    wait_clk_out(1'b0, n);
    wait_clk_out(1'b1, n);
    n = 0;
    wait_clk_out(1'b0, n);
    wait_clk_out(1'b1, n);
    check("clkOutPer", 16'(n), 16'd16);
    rsq_partner_i.dip(12);
    // Let the supply filter settle before enabling brown-out
    step(12);
    check("borOff", 16'(chipReset), 16'h0);
    // Power-up timer stays on while brown-out is enabled
    @(posedge clk) brownoutEnableCfg <= 1'b1;
    rsq_partner_i.dip(2);
    step(6);
    check("shortDip", 16'(chipReset), 16'h0);
    rsq_partner_i.dip(12);
    step(1);
    check("borRst", 16'(chipReset), 16'h1);
    check("cause", 16'(resetCause), 16'(CAUSE_BOR));
    check("flags", 16'(flagVec), 16'h1C);
    wait_run(600, n);
    range_chk("borPwrt", n, PW, PW + 16);
    rsq_partner_i.dip(12);
    step(100);
    rsq_partner_i.dip(12);
    wait_run(600, n);
    range_chk("borRestart", n, PW, PW + 16);
    @(posedge clk) brownoutEnableCfg <= 1'b0;
  endtask

  task automatic t_power_rc();
    int n;
    fork
      rsq_partner_i.power_cycle();
      rsq_partner_i.pin_low(600);
    join
    check("pinHeld", 16'(chipReset), 16'h1);
    check("cause", 16'(resetCause), 16'(CAUSE_POR));
    check("flags", 16'(flagVec), 16'h19);
    wait_run(12, n);
    check("pinGo", 16'(chipReset), 16'h0);
    @(posedge clk) powerupTimerEnCfg <= 1'b0;
    rsq_partner_i.power_cycle();
    wait_cold();
    wait_run(20, n);
    check("noTimeout", 16'(chipReset), 16'h0);
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst_b = 1'b0;
    evt = 8'h00;
    brownoutEnableCfg = 1'b0;
    powerupTimerEnCfg = 1'b1;
    parityEnableCfg = 1'b1;
    oscModeCfg = OSC_XT;
    step(11);
    check("rstHold", 16'(chipReset), 16'h1);
    check("rstFlags", 16'(flagVec), 16'h1B);
    @(posedge clk) rst_b <= 1'b1;
    t_power_xt();
    t_wdt();
    t_pin();
    t_sleep();
    t_brownout();
    t_power_rc();
    end_sim();
  end
endmodule
